// File: lpcs_top.sv
// LED PWM controller: channel select, PWM generation and protection
`include "lpcs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module lpcs_top
  import lpcs_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `LPCS_DEBOUNCE_CYC,
  parameter int PERIOD_CYC = `LPCS_PERIOD_CYC,
  parameter int MAX_ON_CYC = `LPCS_MAX_ON_CYC,
  parameter int BLANK_CYC = `LPCS_BLANK_CYC,
  parameter int MIN_ON_CYC = `LPCS_MIN_ON_CYC,
  parameter int FOLD_CYCLES = `LPCS_FOLD_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  // Supply comparators (asynchronous)
  input wire logic i_supply_turn_on_level,
  input wire logic i_supply_turn_off_level,
  input wire logic i_supply_overvoltage_protect,
  // Line and sense comparators (asynchronous)
  input wire logic i_line_present,
  input wire logic i_led_current_sense,
  input wire logic i_switch_current_limit,
  input wire logic i_switch_current_fold,
  // Control level: pulse width in clock cycles
  input wire logic [15:0] i_ctrl_level,
  // Gate outputs
  output logic o_main_gate_out,
  output logic o_chan_a_gate,
  output logic o_chan_b_gate
);
  localparam int PW = $clog2(PERIOD_CYC + 1);
  localparam int FW = $clog2(FOLD_CYCLES + 1);

  typedef struct packed {
    lpcs_mode_e mode;
    logic chan_b;
    logic swap_pend;
    logic [PW-1:0] phase;
    logic pulse;
    logic [15:0] width;
    logic [FW-1:0] rest;
    logic deb_seen;
  } lpcs_top_s;

  lpcs_top_s st;
  lpcs_top_s next_st;

  logic [6:0] sync_q;
  logic on_lvl, off_lvl, supply_overvoltage_protect, line, led_oc, cs_lim, cs_fold;
  logic deb_done;

  initial begin
    if (PERIOD_CYC < 4) $error("lpcs_top: PERIOD_CYC too small");
    if (MAX_ON_CYC >= PERIOD_CYC) $error("lpcs_top: MAX_ON_CYC too large");
    if (MIN_ON_CYC > MAX_ON_CYC) $error("lpcs_top: MIN_ON_CYC too large");
    if (BLANK_CYC >= MAX_ON_CYC) $error("lpcs_top: BLANK_CYC too large");
    if (BLANK_CYC < 1) $error("lpcs_top: BLANK_CYC too small");
    if (MIN_ON_CYC < 1) $error("lpcs_top: MIN_ON_CYC too small");
    if (FOLD_CYCLES < 1) $error("lpcs_top: FOLD_CYCLES too small");
  end

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  lpcs_sync #(
    .W(7)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async({i_supply_turn_on_level, i_supply_turn_off_level,
              i_supply_overvoltage_protect, i_line_present,
              i_led_current_sense, i_switch_current_limit,
              i_switch_current_fold}),
    .o_sync(sync_q)
  );

  assign {on_lvl, off_lvl, supply_overvoltage_protect, line, led_oc, cs_lim, cs_fold} = sync_q;

  // ---------------------------------------------------------------
  // Line-absence debounce
  // ---------------------------------------------------------------
  lpcs_timer #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_line_present(line),
    .i_active(off_lvl),
    .o_done(deb_done)
  );

  // Clamp requested width into the legal on-time window
  function automatic logic [15:0] clamp_width(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    if (r > 16'(MAX_ON_CYC)) begin
      r = 16'(MAX_ON_CYC);
    end
    if (r < 16'(MIN_ON_CYC)) begin
      r = 16'(MIN_ON_CYC);
    end
    return r;
  endfunction

  // Last cycle of a switching period
  function automatic logic is_period_end(input logic [PW-1:0] ph);
    return ph == PW'(PERIOD_CYC - 1);
  endfunction

  // Pulse has run n cycles, counting the register delay of the gate
  function automatic logic ran_cycles(input logic [PW-1:0] ph,
                                      input int n);
    return int'(ph) >= n - 1;
  endfunction

  // ---------------------------------------------------------------
  // Pulse end causes
  // ---------------------------------------------------------------
  logic period_end;
  logic blank_over;
  logic min_on_over;
  logic fold_trip;
  logic limit_trip;
  logic width_done;

  assign period_end = is_period_end(st.phase);
  // Switch current comparators are ignored until blanking has run out
  assign blank_over = ran_cycles(st.phase, BLANK_CYC);
  assign min_on_over = ran_cycles(st.phase, MIN_ON_CYC);
  assign fold_trip = st.pulse && blank_over && cs_fold;
  assign limit_trip = st.pulse && blank_over && min_on_over
                      && cs_lim;
  // Width is never zero here: the clamp keeps it at MIN_ON_CYC or more
  assign width_done = st.pulse
                      && (16'(st.phase) >= st.width - 16'h0001);

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Free-running switching period
    if (period_end) begin
      next_st.phase = '0;
    end else begin
      next_st.phase = st.phase + PW'(1);
    end

    // Debounce completion arms a channel swap once per line loss
    if (deb_done && !st.deb_seen) begin
      next_st.swap_pend = 1'b1;
      next_st.deb_seen = 1'b1;
    end
    if (line) begin
      next_st.deb_seen = 1'b0;
    end

    unique case (st.mode)
      LPCS_OFF: begin
        // Swap applies on the next turn-on, outputs kept meanwhile
        if (on_lvl && !supply_overvoltage_protect) begin
          next_st.mode = LPCS_RUN;
          next_st.phase = '0;
          if (st.swap_pend) begin
            next_st.chan_b = !st.chan_b;
            next_st.swap_pend = 1'b0;
          end
        end
      end
      LPCS_RUN: begin
        if (!off_lvl) begin
          next_st.mode = LPCS_OFF;
        end else if (supply_overvoltage_protect) begin
          next_st.mode = LPCS_OVP;
        end else if (led_oc) begin
          next_st.mode = LPCS_OCP;
        end
      end
      LPCS_OVP, LPCS_OCP: begin
        // Latched until supply drops below turn-off
        if (!off_lvl) begin
          next_st.mode = LPCS_OFF;
        end
      end
    endcase

    // Pulse generation
    if (next_st.mode != LPCS_RUN || deb_done) begin
      next_st.pulse = 1'b0;
      next_st.rest = '0;
    end else if (period_end) begin
      if (st.rest != '0) begin
        next_st.rest = st.rest - FW'(1);
        next_st.pulse = 1'b0;
      end else begin
        next_st.pulse = 1'b1;
        next_st.width = clamp_width(i_ctrl_level);
      end
    end else if (fold_trip) begin
      next_st.pulse = 1'b0;
      next_st.rest = FW'(FOLD_CYCLES);
    end else if (limit_trip) begin
      next_st.pulse = 1'b0;
    end else if (width_done) begin
      next_st.pulse = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Channel gates independent of mode, so they stay up below turn-off
  assign o_chan_a_gate = !st.chan_b;
  assign o_chan_b_gate = st.chan_b;
  assign o_main_gate_out = st.pulse;
endmodule
`default_nettype wire

// File: lpcs_consts.svh
// Timing constants and rule summary for the LED PWM channel-select block
// Summary of operation
// - Start switching only after supply turn-on indication
// - After full reset, channel A on, B off
// - Line loss starts the debounce timer
// - Completed debounce before turn-off swaps channel next power-up
// - Main gate forced off once debounce elapses
// - Every further qualified off-on toggles channel again
// - Supply below 4.0V resets control, channel A; code only returns to off mode and keeps the selected channel
// - Switch current sense ignored first 750ns
// - Overvoltage stops switching until turn-off then turn-on
// - LED over-current latches gate off until recycle
// - Switch current limit ends pulse, next cycle resumes
// - Below turn-off level main gate is off
// - Second current threshold rests output three cycles
// - Fixed 66 kHz pulses, width from control level
// - Pulse width at most 79 percent of period
// - Every issued pulse at least 250ns long; code ends a pulse at once on a fault, supply drop or debounce end
// - Channel gates stay active below turn-off level
`ifndef LPCS_CONSTS_SVH
`define LPCS_CONSTS_SVH

`define LPCS_CLK_HZ 40000000
`define LPCS_SW_FREQ_HZ 66000
`define LPCS_PERIOD_CYC (`LPCS_CLK_HZ / `LPCS_SW_FREQ_HZ)
`define LPCS_MAX_DUTY_PCT 79
`define LPCS_MAX_ON_CYC ((`LPCS_PERIOD_CYC * `LPCS_MAX_DUTY_PCT) / 100)
`define LPCS_BLANK_NS 750
`define LPCS_BLANK_CYC ((`LPCS_BLANK_NS * (`LPCS_CLK_HZ / 1000000) + 999) / 1000)
`define LPCS_MIN_ON_NS 250
`define LPCS_MIN_ON_CYC ((`LPCS_MIN_ON_NS * (`LPCS_CLK_HZ / 1000000) + 999) / 1000)
`define LPCS_DEBOUNCE_MS 19
`define LPCS_DEBOUNCE_CYC (`LPCS_DEBOUNCE_MS * (`LPCS_CLK_HZ / 1000))
`define LPCS_FOLD_CYCLES 3

`endif

// File: lpcs_pkg.sv
// Types shared by the LED PWM channel-select block
package lpcs_pkg;
  typedef enum logic [1:0] {
    LPCS_OFF = 2'b00,
    LPCS_RUN = 2'b01,
    LPCS_OVP = 2'b10,
    LPCS_OCP = 2'b11
  } lpcs_mode_e;
endpackage

// File: lpcs_sync.sv
// Three-stage synchroniser with agreement filter for comparator inputs
`timescale 1ns/10ps
`default_nettype none
module lpcs_sync #(
  parameter int W = 7
) (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lpcs_sync_s;

  lpcs_sync_s st;
  lpcs_sync_s next_st;

  initial begin
    if (W < 1) $error("lpcs_sync: W must be positive");
  end

  always_comb begin
    next_st = st;
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Change accepted only when stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_sync = st.q;
endmodule
`default_nettype wire

// File: lpcs_timer.sv
// Line-absence debounce timer
`timescale 1ns/10ps
`default_nettype none
module lpcs_timer #(
  parameter int DEBOUNCE_CYC = 760000
) (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  // Line state
  input wire logic i_line_present,
  input wire logic i_active,
  // Result
  output logic o_done
);
  localparam int CW = $clog2(DEBOUNCE_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } lpcs_timer_s;

  lpcs_timer_s st;
  lpcs_timer_s next_st;

  initial begin
    if (DEBOUNCE_CYC < 2) $error("lpcs_timer: DEBOUNCE_CYC too small");
  end

  always_comb begin
    next_st = st;
    if (i_line_present || !i_active) begin
      next_st.cnt = '0;
      next_st.done = 1'b0;
    end else if (!st.done) begin
      // Counts only while line is absent and supply held
      if (st.cnt == CW'(DEBOUNCE_CYC - 1)) begin
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_done = st.done;
endmodule
`default_nettype wire

// File: lpcs_top_checker.sv
// Assertion checker for the LED PWM channel-select block
`timescale 1ns/10ps
`default_nettype none
module lpcs_top_checker #(
  parameter int DEBOUNCE_CYC = 50,
  parameter int MAX_ON_CYC = 30
) (
  // Watched ports
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_supply_turn_off_level,
  input wire logic i_supply_overvoltage_protect,
  input wire logic i_line_present,
  input wire logic i_led_current_sense,
  input wire logic [15:0] i_ctrl_level,
  input wire logic o_main_gate_out,
  input wire logic o_chan_a_gate,
  input wire logic o_chan_b_gate
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  int on_cnt;
  int ln_cnt;
  // ----------
  // Run lengths
  // ----------
  always_ff @(posedge i_clk_sys) begin
    // Held while the clock enable freezes the block
    on_cnt <= (o_main_gate_out && !i_reset) ? on_cnt + (i_ce ? 1 : 0) : 0;
    ln_cnt <= (!i_line_present && i_supply_turn_off_level && !i_reset) ?
      ln_cnt + 1 : 0;
  end
  // ----------
  // Properties
  // ----------
  chk_reset_chan: assert property ($past(i_reset) |->
    o_chan_a_gate && !o_chan_b_gate && !o_main_gate_out)
    else $error("bad state after reset");
  chk_one_chan: assert property (o_chan_a_gate ^ o_chan_b_gate)
    else $error("channel gates not exclusive");
  chk_deb_off: assert property (ln_cnt > DEBOUNCE_CYC + 8 |->
    !o_main_gate_out) else $error("gate on after line loss");
  chk_off_low: assert property (!i_supply_turn_off_level [*8] |->
    !o_main_gate_out) else $error("gate on below turn-off");
  chk_ovp_stop: assert property (i_supply_overvoltage_protect [*8] |->
    !o_main_gate_out) else $error("gate on in overvoltage");
  chk_led_oc: assert property (i_led_current_sense [*8] |->
    !o_main_gate_out) else $error("gate on in led overcurrent");
  chk_max_width: assert property (o_main_gate_out |->
    on_cnt < MAX_ON_CYC) else $error("pulse too long");
  chk_min_width: assert property ($rose(o_main_gate_out) &&
    i_line_present |=> o_main_gate_out [*2]) else $error("pulse too short");
  // Needs a blanking time of 9 cycles or more in the bound design
  chk_blank_hold: assert property ($rose(o_main_gate_out) &&
    i_line_present && i_ctrl_level >= 16'h0008 |=> o_main_gate_out [*8])
    else $error("pulse cut in blanking");
  cover property ($rose(o_chan_b_gate));
  cover property (ln_cnt == DEBOUNCE_CYC);
  cover property ($fell(o_main_gate_out) && i_line_present);
endmodule
`default_nettype wire

// File: lpcs_switch_model.sv
// Model of the external switch and its current sense comparators
`timescale 1ns/10ps
`default_nettype none
module lpcs_switch_model (
  // Gate drive and fault setup
  input wire logic i_clk_sys,
  input wire logic i_main_gate_out,
  input wire logic [7:0] i_lim_at,
  input wire logic [7:0] i_fold_at,
  // Sense comparators
  output logic o_switch_current_limit,
  output logic o_switch_current_fold
);
  logic [7:0] on_cnt = 8'h00;
  // Current ramps only while the switch conducts, zero when off
  always @(posedge i_clk_sys) begin
    on_cnt <= i_main_gate_out ? on_cnt + 8'h01 : 8'h00;
  end
  assign o_switch_current_limit = i_lim_at != 8'h00 && on_cnt >= i_lim_at;
  assign o_switch_current_fold = i_fold_at != 8'h00 && on_cnt >= i_fold_at;
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the LED PWM channel-select block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, on = 1'b0, off = 1'b0, supply_overvoltage_protect = 1'b0;
  logic line = 1'b1, led = 1'b0, lim, fold, gate, cha, chb, ce = 1'b1;
  logic [15:0] ctrl = 16'h0014;
  logic [7:0] lim_at = 8'h00, fold_at = 8'h00;
  logic [3:0] bef = 4'b0110, aft = 4'b1011;
  int mismatches = 0, samples_checked = 0, w, p;
  logic [15:0] rows [5][2] = '{'{16'h0001, 16'h0003},
    '{16'h0003, 16'h0003}, '{16'h000C, 16'h000C},
    '{16'h001E, 16'h001E}, '{16'h00C8, 16'h001E}};
  initial forever #12.5 clk = ~clk;
  lpcs_top #(.DEBOUNCE_CYC(50), .PERIOD_CYC(40), .MAX_ON_CYC(30),
    .BLANK_CYC(10), .MIN_ON_CYC(3)) dut (
    .i_clk_sys(clk), .i_reset(rst), .i_ce(ce),
    .i_supply_turn_on_level(on), .i_supply_turn_off_level(off),
    .i_supply_overvoltage_protect(supply_overvoltage_protect), .i_line_present(line),
    .i_led_current_sense(led), .i_switch_current_limit(lim),
    .i_switch_current_fold(fold), .i_ctrl_level(ctrl),
    .o_main_gate_out(gate), .o_chan_a_gate(cha), .o_chan_b_gate(chb));
  lpcs_switch_model fet (.i_clk_sys(clk), .i_main_gate_out(gate),
    .i_lim_at(lim_at), .i_fold_at(fold_at),
    .o_switch_current_limit(lim), .o_switch_current_fold(fold));
  // ----------
  // Helpers
  // ----------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Capped so a stuck gate shows up as a bad count, not a hang
  task automatic wait_gate(input logic lvl, output int n);
    n = 0;
    while (gate !== lvl && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic pulse(output int wd, output int per);
    int g;
    wait_gate(1'b0, wd);
    wait_gate(1'b1, wd);
    wait_gate(1'b0, wd);
    wait_gate(1'b1, g);
    per = wd + g;
  endtask
  task automatic quiet(input string nm, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      seen = seen | gate;
    end
    check(nm, {15'h0, seen}, 16'h0000);
  endtask
  task automatic supply(input logic up_on, input logic up_off);
    on = up_on;
    off = up_off;
    cyc(20);
  endtask
  task automatic finish_test;
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    // Whole sequence runs in a few thousand cycles
    #(25 * 20000);
    mismatches++;
    finish_test;
  end
  initial begin
    cyc(4);
    rst = 1'b0;
    off = 1'b1;
    quiet("early gate", 100);
    check("chans", {14'h0, cha, chb}, 16'h0002);
    on = 1'b1;
    foreach (rows[i]) begin
      ctrl = rows[i][0];
      cyc(90);
      pulse(w, p);
      check("width", w[15:0], rows[i][1]);
      check("period", p[15:0], 16'h0028);
    end
    // Gate just rose: a frozen block must hold it past its width
    ce = 1'b0;
    cyc(60);
    check("frozen gate", {15'h0, gate}, 16'h0001);
    ce = 1'b1;
    pulse(w, p);
    check("thawed width", w[15:0], 16'h001E);
    check("thawed period", p[15:0], 16'h0028);
    ctrl = 16'h0014;
    lim_at = 8'h01;
    cyc(90);
    pulse(w, p);
    // Limit goes high one cycle into the pulse, so the pulse lasts the blanking time
    check("limit cut", w[15:0], 16'h000A);
    check("limit period", p[15:0], 16'h0028);
    lim_at = 8'h00;
    fold_at = 8'h06;
    pulse(w, p);
    check("fold gap", p[15:0], 16'h00A0);
    fold_at = 8'h00;
    for (int k = 0; k < 2; k++) begin
      // Fault lands after blanking so the pulse is not cut inside it
      cyc(10);
      {led, supply_overvoltage_protect} = k[0] ? 2'b10 : 2'b01;
      cyc(20);
      {led, supply_overvoltage_protect} = 2'b00;
      quiet("fault rest", 200);
      supply(1'b0, 1'b0);
      supply(1'b1, 1'b1);
      pulse(w, p);
      check("resume", p[15:0], 16'h0028);
    end
    for (int k = 0; k < 4; k++) begin
      line = 1'b0;
      cyc(k == 1 ? 20 : 80);
      if (k != 1) check("debounced", {15'h0, gate}, 16'h0000);
      supply(1'b0, 1'b0);
      quiet("supply off", 20);
      check("held", {14'h0, cha, chb}, {14'h0, !bef[k], bef[k]});
      line = 1'b1;
      supply(1'b1, 1'b1);
      check("swap", {14'h0, cha, chb},
        {14'h0, !aft[k], aft[k]});
    end
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    check("chans reset", {14'h0, cha, chb}, 16'h0002);
    check("gate reset", {15'h0, gate}, 16'h0000);
    finish_test;
  end
endmodule
bind lpcs_top lpcs_top_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC),
  .MAX_ON_CYC(MAX_ON_CYC)) u_chk (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_ce(i_ce),
  .i_supply_turn_off_level(i_supply_turn_off_level),
  .i_supply_overvoltage_protect(i_supply_overvoltage_protect),
  .i_line_present(i_line_present), .i_led_current_sense(i_led_current_sense),
  .i_ctrl_level(i_ctrl_level), .o_main_gate_out(o_main_gate_out),
  .o_chan_a_gate(o_chan_a_gate), .o_chan_b_gate(o_chan_b_gate));
`default_nettype wire
